// ### common/serr_defs.svh
// Register offsets, field positions and reset values of the event and result bank
`ifndef SERR_DEFS_SVH
`define SERR_DEFS_SVH
`define SERR_OFF_CMD_MAILBOX 8'h18
`define SERR_OFF_EVENT_FLAGS 8'h21
`define SERR_OFF_VIS_LO 8'h22
`define SERR_OFF_VIS_HI 8'h23
`define SERR_OFF_IR_LO 8'h24
`define SERR_OFF_IR_HI 8'h25
`define SERR_OFF_PS1_LO 8'h26
`define SERR_OFF_PS1_HI 8'h27
`define SERR_OFF_PS2_LO 8'h28
`define SERR_BIT_CMD_FLAG 5
`define SERR_BIT_PS3_FLAG 4
`define SERR_BIT_PS2_FLAG 3
`define SERR_BIT_PS1_FLAG 2
`define SERR_AMB_MSB 1
`define SERR_AMB_LSB 0
`define SERR_FLAG_MASK 8'h3F
`define SERR_RESET_BYTE 8'h00
`define SERR_IM_HOLD 2'h3
`define SERR_NUM_RESULTS 7
`endif

// ### common/serr_pkg.sv
// Types shared by the event and result bank
package serr_pkg;
  typedef enum logic [1:0] {
    SERR_CLR_HOST,
    SERR_CLR_AUTO
  } serr_clr_mode_t;
  typedef enum logic [1:0] {
    SERR_SEQ_STANDBY,
    SERR_SEQ_AWAKE
  } serr_seq_state_t;
endpackage : serr_pkg

// ### core/serr_result_mem.sv
// Result byte storage with registered read data
`timescale 1ns/1ps
`include "serr_defs.svh"
module serr_result_mem #(
  parameter int DEPTH = 7
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [2:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  // Read port
  input wire logic [2:0] rd_idx_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [DEPTH];

  // =======================================
  // Storage
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mem[g] <= `SERR_RESET_BYTE; // see (RL10)
        end else if (wr_en_i && wr_idx_i == 3'(g)) begin
          mem[g] <= wr_data_i;
        end
      end
    end
  endgenerate

  // =======================================
  // Read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= `SERR_RESET_BYTE;
    end else if (int'(rd_idx_i) < DEPTH) begin
      rd_data_o <= mem[rd_idx_i];
    end else begin
      rd_data_o <= `SERR_RESET_BYTE;
    end
  end
endmodule : serr_result_mem

// ### core/serr_irq_gate.sv
// Interrupt output from flags and enables
`timescale 1ns/1ps
module serr_irq_gate #(
  parameter int WIDTH = 6
) (
  // Flags and enables
  input wire logic [WIDTH-1:0] flags_i,
  input wire logic [WIDTH-1:0] enables_i,
  // Interrupt
  output logic irq_o
);
  assign irq_o = |(flags_i & enables_i); // see (RL2)
endmodule : serr_irq_gate

// ### core/serr_regs.sv
// Event flag and measurement result registers of the sensor
// Function
// (RL1) Flags: command bit 5, proximity 3/2/1 bits 4/3/2, ambient field bits 1:0.
// (RL2) Interrupt asserts while any flag and its enable are both set.
// (RL3) Host clear mode: flags stay set until host writes one to them.
// (RL4) Auto clear mode: sequencer clears flags except proximity channels in mode 11.
// (RL5) Visible result word at 0x22 low, 0x23 high.
// (RL6) Infrared result word at 0x24 low, 0x25 high.
// (RL7) Proximity 1 result word at 0x26 low, 0x27 high.
// (RL8) Proximity 2 result low byte at 0x28.
// (RL9) Host reads results after interrupt, before next measurement overwrites.
// (RL10) Flags and all results reset to zero.
// (RL11) Only a host write to the command mailbox wakes the sequencer.
// (RL12) Flag bits 7:6 read zero and ignore writes.
`timescale 1ns/1ps
`include "serr_defs.svh"
module serr_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Host register port
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Configuration from elsewhere in the device
  input wire logic [5:0] irq_enable_i,
  input wire logic clr_mode_i,
  input wire logic [1:0] prox_irq_mode_param_i [3],
  // Sequencer side
  input wire logic seq_sleep_i,
  input wire logic seq_auto_clear_i,
  input wire logic [5:0] event_set_i,
  input wire logic [1:0] ambient_set_i,
  input wire logic res_wr_i,
  input wire logic [2:0] res_idx_i,
  input wire logic [7:0] res_data_i,
  output logic seq_awake_o,
  output logic wake_o,
  // Interrupt pin
  output logic irq_o
);
  logic [5:0] event_flags;
  logic [5:0] next_event_flags;
  logic [5:0] host_clr;
  logic [5:0] auto_clr;
  logic [5:0] hw_set;
  logic host_wr_res;
  logic [3:0] host_res_sel;
  logic [2:0] host_res_idx;
  logic mem_wr;
  logic [2:0] mem_wr_idx;
  logic [7:0] mem_wr_data;
  logic [7:0] mem_rdata;
  logic [7:0] flag_rdata;
  logic rd_is_flag;
  logic rd_is_res;
  serr_pkg::serr_seq_state_t seq_state;

  // =======================================
  // Address decode of result bytes
  function automatic logic [3:0] res_index(input logic [7:0] a);
    case (a)
      `SERR_OFF_VIS_LO: res_index = 4'h0; // see (RL5)
      `SERR_OFF_VIS_HI: res_index = 4'h1; // see (RL5)
      `SERR_OFF_IR_LO: res_index = 4'h2; // see (RL6)
      `SERR_OFF_IR_HI: res_index = 4'h3; // see (RL6)
      `SERR_OFF_PS1_LO: res_index = 4'h4; // see (RL7)
      `SERR_OFF_PS1_HI: res_index = 4'h5; // see (RL7)
      `SERR_OFF_PS2_LO: res_index = 4'h6; // see (RL8)
      default: res_index = 4'h8;
    endcase
  endfunction : res_index

  // Bit 3 of the selector marks an address outside the result bytes
  assign host_res_sel = res_index(addr_i);
  assign host_res_idx = host_res_sel[2:0];
  assign host_wr_res = wr_i && !host_res_sel[3];

  // =======================================
  // Event flags
  always_comb begin
    hw_set = event_set_i;
    hw_set[`SERR_AMB_MSB:`SERR_AMB_LSB] = ambient_set_i;
    host_clr = 6'h00;
    auto_clr = 6'h00;
    if (wr_i && addr_i == `SERR_OFF_EVENT_FLAGS && clr_mode_i == 1'b0) begin
      host_clr = wdata_i[5:0]; // see (RL3) (RL12)
    end
    if (seq_auto_clear_i && clr_mode_i == 1'b1) begin
      auto_clr = 6'h3F; // see (RL4)
      for (int i = 0; i < 3; i++) begin
        if (prox_irq_mode_param_i[i] == `SERR_IM_HOLD) begin
          auto_clr[`SERR_BIT_PS1_FLAG + i] = 1'b0; // see (RL4)
        end
      end
    end
    // Set wins over a same-cycle clear
    next_event_flags = (event_flags & ~(host_clr | auto_clr)) | hw_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_flags <= 6'h00; // see (RL10)
    end else begin
      event_flags <= next_event_flags; // see (RL1)
    end
  end

  assign flag_rdata = {2'b00, event_flags} & `SERR_FLAG_MASK; // see (RL12)

  // =======================================
  // Sequencer wake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_state <= serr_pkg::SERR_SEQ_STANDBY;
    end else begin
      case (seq_state)
        serr_pkg::SERR_SEQ_STANDBY: begin
          if (wr_i && addr_i == `SERR_OFF_CMD_MAILBOX) begin
            seq_state <= serr_pkg::SERR_SEQ_AWAKE; // see (RL11)
          end
        end
        serr_pkg::SERR_SEQ_AWAKE: begin
          if (seq_sleep_i) begin
            seq_state <= serr_pkg::SERR_SEQ_STANDBY;
          end
        end
        default: seq_state <= serr_pkg::SERR_SEQ_STANDBY;
      endcase
    end
  end

  assign wake_o = wr_i && addr_i == `SERR_OFF_CMD_MAILBOX; // see (RL11)
  assign seq_awake_o = seq_state == serr_pkg::SERR_SEQ_AWAKE;

  // =======================================
  // Result storage; sequencer write overrides host
  assign mem_wr = res_wr_i || host_wr_res;
  assign mem_wr_idx = res_wr_i ? res_idx_i : host_res_idx;
  assign mem_wr_data = res_wr_i ? res_data_i : wdata_i; // see (RL9)

  serr_result_mem #(
    .DEPTH(`SERR_NUM_RESULTS)
  ) u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(mem_wr),
    .wr_idx_i(mem_wr_idx),
    .wr_data_i(mem_wr_data),
    .rd_idx_i(host_res_idx),
    .rd_data_o(mem_rdata)
  );

  // =======================================
  // Read data, one cycle after rd_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_is_flag <= 1'b0;
      rd_is_res <= 1'b0;
    end else begin
      rd_is_flag <= rd_i && addr_i == `SERR_OFF_EVENT_FLAGS;
      rd_is_res <= rd_i && !host_res_sel[3];
    end
  end

  logic [7:0] flag_rdata_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_rdata_q <= `SERR_RESET_BYTE;
    end else begin
      flag_rdata_q <= flag_rdata;
    end
  end

  assign rdata_o = rd_is_flag ? flag_rdata_q : (rd_is_res ? mem_rdata : 8'h00);

  // =======================================
  // Interrupt pin
  serr_irq_gate #(
    .WIDTH(6)
  ) u_irq (
    .flags_i(event_flags),
    .enables_i(irq_enable_i),
    .irq_o(irq_o)
  );
endmodule : serr_regs

// ### verification/serr_regs_checker.sv
// Port checker of the event and result bank
`timescale 1ns/1ps
// ====
// Checker
module serr_regs_checker (
  // Watched ports
  input wire logic clk_i, rst_i, wr_i, rd_i, clr_mode_i, seq_auto_clear_i, seq_sleep_i,
  input wire logic [7:0] addr_i, rdata_o,
  input wire logic [5:0] irq_enable_i, event_set_i,
  input wire logic [1:0] ambient_set_i, prox_irq_mode_param_i [3],
  input wire logic seq_awake_o, wake_o, irq_o
);
  logic hold;
  assign hold = prox_irq_mode_param_i[0] == 2'h3 || prox_irq_mode_param_i[1] == 2'h3
    || prox_irq_mode_param_i[2] == 2'h3;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rst; $past(rst_i) |-> !irq_o && !seq_awake_o && rdata_o == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("not clear after reset");
  property p_irq; irq_o |-> irq_enable_i != 6'h00; endproperty
  a_irq: assert property (p_irq) else $error("irq without enable");
  property p_hold; irq_o && !clr_mode_i && !wr_i ##1 $stable(irq_enable_i) |-> irq_o; endproperty
  a_hold: assert property (p_hold) else $error("flag lost in host mode");
  property p_auto; clr_mode_i && seq_auto_clear_i && event_set_i[5:2] == 4'h0
    && ambient_set_i == 2'h0 && !hold |=> !irq_o; endproperty
  a_auto: assert property (p_auto) else $error("auto clear missed");
  property p_rsv; $past(rd_i) && $past(addr_i) == 8'h21 |-> rdata_o[7:6] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag bits set");
  property p_wake; wake_o == (wr_i && addr_i == 8'h18); endproperty
  a_wake: assert property (p_wake) else $error("wake on wrong access");
  property p_up; wake_o && !seq_sleep_i |=> seq_awake_o; endproperty
  a_up: assert property (p_up) else $error("not awake after wake");
  property p_rose; $rose(seq_awake_o) |-> $past(wake_o); endproperty
  a_rose: assert property (p_rose) else $error("awake without wake");
  cover property (irq_o);
  cover property (clr_mode_i && seq_auto_clear_i);
  cover property (wake_o);
endmodule : serr_regs_checker
bind serr_regs serr_regs_checker u_chk (.clk_i, .rst_i, .wr_i, .rd_i, .clr_mode_i,
  .seq_auto_clear_i, .seq_sleep_i, .addr_i, .rdata_o, .irq_enable_i, .event_set_i,
  .ambient_set_i, .prox_irq_mode_param_i, .seq_awake_o, .wake_o, .irq_o);

// ### verification/serr_seq_model.sv
// Sequencer model feeding events and results into the bank
`timescale 1ns/1ps
// ====
// Model
module serr_seq_model (
  // Clock
  input wire logic clk_i,
  // Sequencer side
  output logic sleep_o, aclr_o, wr_o,
  output logic [5:0] ev_o,
  output logic [1:0] amb_o,
  output logic [2:0] idx_o,
  output logic [7:0] data_o
);
  initial {sleep_o, aclr_o, wr_o, ev_o, amb_o, idx_o, data_o} = '0;
  task meas(input logic [2:0] i, input logic [7:0] d, input logic [5:0] e, input logic [1:0] a);
    @(posedge clk_i);
    {wr_o, idx_o, data_o, ev_o, amb_o} <= {1'b1, i, d, e, a};
    @(posedge clk_i);
    {wr_o, data_o, ev_o, amb_o} <= {1'b0, ~d, 6'h00, 2'h0};
  endtask : meas
  task ctl(input logic [1:0] k);
    @(posedge clk_i);
    {sleep_o, aclr_o} <= k;
    @(posedge clk_i);
    {sleep_o, aclr_o} <= 2'h0;
  endtask : ctl
endmodule : serr_seq_model

// ### verification/serr_regs_tb_top.sv
// Testbench of the event and result bank
`timescale 1ns/1ps
// ====
// Bench
module serr_regs_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr, rd, clr, sl, ac, rw, awake, wake, irq;
  logic [7:0] addr, wdata, rdata_o, rdat;
  logic [5:0] en, ev;
  logic [1:0] amb, mp [3];
  logic [2:0] idx;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  always #50 clk_i = ~clk_i;
  serr_regs uut (.clk_i, .rst_i, .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata),
    .rdata_o, .irq_enable_i(en), .clr_mode_i(clr), .prox_irq_mode_param_i(mp),
    .seq_sleep_i(sl), .seq_auto_clear_i(ac), .event_set_i(ev), .ambient_set_i(amb),
    .res_wr_i(rw), .res_idx_i(idx), .res_data_i(rdat), .seq_awake_o(awake),
    .wake_o(wake), .irq_o(irq));
  serr_seq_model seq (.clk_i, .sleep_o(sl), .aclr_o(ac), .wr_o(rw), .ev_o(ev),
    .amb_o(amb), .idx_o(idx), .data_o(rdat));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {addr, wdata, wr, rd} <= {a, d, w, !w};
    @(posedge clk_i);
    {wr, rd} <= 2'h0;
    #1;
  endtask : acc
  task rchk(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(rdata_o, e);
  endtask : rchk
  task stop_test;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    {wr, rd, clr, addr, wdata, en} = '0;
    mp = '{default: 2'h0};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 8'h21; i <= 8'h28; i++) rchk(8'(i), 8'h00);
    rchk(8'h40, 8'h00);
    acc(1'b1, 8'h21, 8'hFF);
    rchk(8'h21, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      seq.meas(3'(i), 8'hA0 + 8'(i), 6'h00, 2'h0);
      rchk(8'h22 + 8'(i), 8'hA0 + 8'(i));
    end
    acc(1'b1, 8'h23, 8'h5A);
    rchk(8'h23, 8'h5A);
    $display("test results done");
    @(posedge clk_i) en <= 6'h3F;
    seq.meas(3'h6, 8'h11, 6'h3C, 2'h3);
    rchk(8'h21, 8'h3F);
    chk({7'h0, irq}, 8'h01);
    acc(1'b1, 8'h21, 8'h04);
    rchk(8'h21, 8'h3B);
    @(posedge clk_i) en <= 6'h04;
    #1 chk({7'h0, irq}, 8'h00);
    @(posedge clk_i) en <= 6'h08;
    #1 chk({7'h0, irq}, 8'h01);
    $display("test flags done");
    @(posedge clk_i) clr <= 1'b1;
    mp[1] <= 2'h3;
    acc(1'b1, 8'h21, 8'h3B);
    rchk(8'h21, 8'h3B);
    seq.ctl(2'h1);
    rchk(8'h21, 8'h08);
    mp[1] <= 2'h0;
    seq.ctl(2'h1);
    rchk(8'h21, 8'h00);
    $display("test auto clear done");
    acc(1'b1, 8'h21, 8'h00);
    chk({7'h0, awake}, 8'h00);
    @(posedge clk_i) {addr, wdata, wr} <= {8'h18, 8'h01, 1'b1};
    #1 chk({7'h0, wake}, 8'h01);
    @(posedge clk_i) wr <= 1'b0;
    #1 chk({7'h0, awake}, 8'h01);
    chk({7'h0, wake}, 8'h00);
    seq.ctl(2'h2);
    #1 chk({7'h0, awake}, 8'h00);
    $display("test wake done");
    stop_test();
  end
endmodule : serr_regs_tb_top
